// File: rtl/smpm_top.sv
// Power-management capability registers and system-management request framing.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: Header identifier field reads the fixed link capability value.
// R2: Next pointer reads the following capability location, zero when last.
// R3: Data port reads and writes the indirect register chosen by index.
// R4: Capability type field reads the five-bit power-management pattern.
// R5: Register 0 exists; enables without matching support bit are reserved.
// R6: Bit 21 disconnected-lane refresh enable, read-write, warm reset clears.
// R7: Bit 20 inactive-lane refresh enable, read-write, only cold reset clears.
// R8: Bit 19 frequency override enable, read-write, cold reset clears.
// R9: Bit 18 width override enable, read-write, cold reset clears.
// R10: Bits 17 and 16 disconnect and configuration enables, warm reset clears.
// R11: Bits 5:0 are read-only support flags; frequency support brings register 1.
// R12: Register 1 is a 16-bit allowed-frequency mask, warm reset clears.
// R13: Register 2 bits 11:6 give longest disconnected time before refresh.
// R14: Register 2 bits 5:0 give shortest refresh length, warm reset clears.
// R15: Upstream requests are posted sized writes with zero count, masks, flags.
// R16: Command bits go in bit-times 4 and 5, address in 6 and 7.
// R17: Downstream requests are broadcasts recognised by system-management address.
// R18: The full twelve-bit command is decoded.
// R19: Shutdown and halt patterns decode as special cycles with free low bits.
// R20: Interrupt wire commands select wire by bits 3:2, level by bit 1.
// R21: One exact value is interrupt-pending; the range above is vendor wires.
// R22: Issuers send management or reserved codes only when software enabled; the upstream framer sends any req_cmd without checking an enable.
// R23: Reserved commands are ignored; every packet is forwarded unaltered.
module smpm_top #(
	parameter logic [7:0]  NEXT_PTR    = 8'h00,
	parameter logic [5:0]  SUPPORT     = 6'h3F,
	parameter logic [15:0] SYSMGT_BASE = 16'h0000
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        warm_rst_b,
	input  wire logic        cfg_req,
	input  wire logic        cfg_wr,
	input  wire logic        cfg_sel,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic             cfg_ack_ff,
	output logic [31:0]      cfg_rdata_ff,
	input  wire logic        rx_valid,
	input  wire logic        rx_sop,
	input  wire logic [7:0]  rx_byte,
	output logic             fwd_valid_ff,
	output logic             fwd_sop_ff,
	output logic [7:0]       fwd_byte_ff,
	input  wire logic        req_valid,
	input  wire logic [11:0] req_cmd,
	input  wire logic [4:0]  req_unit,
	output logic             req_ready_ff,
	output logic             up_valid_ff,
	output logic             up_sop_ff,
	output logic [7:0]       up_byte_ff,
	output logic             sm_event_ff,
	output logic [11:0]      sm_cmd_ff,
	output logic             shutdown_ff,
	output logic             halt_ff,
	output logic [3:0]       intx_wire_ff,
	output logic             int_pending_ff,
	output logic             vendor_vw_ff,
	output logic             legacy_cmd_ff,
	output logic             central_link_manager_cmd_ff,
	output logic [5:0]       feature_en_ff,
	output logic [15:0]      allowed_freq_mask_ff,
	output logic [11:0]      refresh_cfg_ff
);
	// ========================================================
	// Functions
	// Merges written bytes into a register word under the byte enables.
	function automatic logic [31:0] be_merge(
		input logic [31:0] old_word,
		input logic [31:0] new_word,
		input logic [3:0]  be
	);
		logic [31:0] res;
		res = old_word;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_word[i*8 +: 8];
			end
		end
		return res;
	endfunction : be_merge

	// ========================================================
	// Declarations
	logic [7:0]   index_ff;
	logic [31:0]  nxt_rdata;
	logic [31:0]  feature_word;
	logic [31:0]  freq_word;
	logic [31:0]  refresh_word;
	logic [31:0]  wr_feature;
	logic [31:0]  wr_freq;
	logic [31:0]  wr_refresh;
	logic [5:0]   en_wmask;
	logic         freq_present;
	logic         dp_wr;
	logic [2:0]   rx_cnt_ff;
	logic         rx_busy_ff;
	logic [5:0]   rx_code_ff;
	logic [11:0]  rx_cmd_ff;
	logic [15:0]  rx_addr_ff;
	logic         rx_done_ff;
	logic         rx_take;
	logic         sm_hit;
	logic [3:0]   up_cnt_ff;
	logic         up_busy_ff;
	logic [11:0]  up_cmd_ff;
	logic [4:0]   up_unit_ff;
	logic [7:0]   nxt_up_byte;
	smpm_dec_if   dec_bus ();

	// ========================================================
	// Register views
	// Enable bits without a matching support flag stay at zero and ignore writes.
	assign en_wmask     = SUPPORT; // [R5]
	assign freq_present = SUPPORT[smpm_pkg::SUP_FREQ_BIT]; // [R11]
	assign feature_word = {10'h000, feature_en_ff, 10'h000, SUPPORT}; // [R11]
	assign freq_word    = freq_present ? {16'h0000, allowed_freq_mask_ff} : 32'h0000_0000;
	assign refresh_word = {20'h0_0000, refresh_cfg_ff}; // [R13] [R14]
	assign dp_wr        = cfg_req && cfg_wr && (cfg_sel == smpm_pkg::SEL_DATA_PORT);
	assign wr_feature   = be_merge(feature_word, cfg_wdata, cfg_be);
	assign wr_freq      = be_merge(freq_word, cfg_wdata, cfg_be);
	assign wr_refresh   = be_merge(refresh_word, cfg_wdata, cfg_be);

	// Read data: header dword or the indirect register named by the index.
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (cfg_sel == smpm_pkg::SEL_HEADER) begin
			nxt_rdata[smpm_pkg::HDR_ID_LSB +: 8]   = smpm_pkg::CAP_ID; // [R1]
			nxt_rdata[smpm_pkg::HDR_PTR_LSB +: 8]  = NEXT_PTR; // [R2]
			nxt_rdata[smpm_pkg::HDR_IDX_LSB +: 8]  = index_ff;
			nxt_rdata[smpm_pkg::HDR_TYPE_LSB +: 5] = smpm_pkg::CAP_TYPE; // [R4]
		end else begin
			case (index_ff) // [R3]
				smpm_pkg::IDX_FEATURE: begin
					nxt_rdata = feature_word;
				end
				smpm_pkg::IDX_FREQ: begin
					nxt_rdata = freq_word;
				end
				smpm_pkg::IDX_REFRESH: begin
					nxt_rdata = refresh_word;
				end
				default: begin
					nxt_rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// ========================================================
	// Configuration access answer
	// Every request is answered one edge later with registered read data.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cfg_ack_ff   <= 1'b0;
			cfg_rdata_ff <= 32'h0000_0000;
		end else begin
			cfg_ack_ff   <= cfg_req;
			cfg_rdata_ff <= cfg_req && !cfg_wr ? nxt_rdata : 32'h0000_0000;
		end
	end

	// Index byte of the header, held across warm reset with the other index state.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			index_ff <= 8'h00;
		end else if (cfg_req && cfg_wr && cfg_sel == smpm_pkg::SEL_HEADER && cfg_be[2]) begin
			index_ff <= cfg_wdata[smpm_pkg::HDR_IDX_LSB +: 8]; // [R3]
		end
	end

	// ========================================================
	// Feature enables
	// Warm reset clears bits 21, 17 and 16; bits 20 to 18 survive it.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			feature_en_ff <= smpm_pkg::FEATURE_RST; // [R7] [R8] [R9]
		end else if (!warm_rst_b) begin
			feature_en_ff <= feature_en_ff & ~smpm_pkg::EN_WARM_MASK; // [R6] [R10]
		end else if (dp_wr && index_ff == smpm_pkg::IDX_FEATURE) begin
			feature_en_ff <= wr_feature[smpm_pkg::EN_LSB +: 6] & en_wmask; // [R5] [R6] [R7]
		end
	end

	// Allowed frequency mask; absent when frequency change is unsupported.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			allowed_freq_mask_ff <= smpm_pkg::FREQ_RST;
		end else if (!warm_rst_b) begin
			allowed_freq_mask_ff <= smpm_pkg::FREQ_RST; // [R12]
		end else if (dp_wr && index_ff == smpm_pkg::IDX_FREQ && freq_present) begin
			allowed_freq_mask_ff <= wr_freq[15:0]; // [R12] [R11]
		end
	end

	// Refresh interval (11:6) and length (5:0), both warm-reset fields.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			refresh_cfg_ff <= smpm_pkg::REFRESH_RST;
		end else if (!warm_rst_b) begin
			refresh_cfg_ff <= smpm_pkg::REFRESH_RST; // [R14]
		end else if (dp_wr && index_ff == smpm_pkg::IDX_REFRESH) begin
			refresh_cfg_ff <= wr_refresh[11:0]; // [R13] [R14]
		end
	end

	// ========================================================
	// Downstream receive
	// Every received bit-time is passed on untouched, one cycle later.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			fwd_valid_ff <= 1'b0;
			fwd_sop_ff   <= 1'b0;
			fwd_byte_ff  <= 8'h00;
		end else begin
			fwd_valid_ff <= rx_valid; // [R23]
			fwd_sop_ff   <= rx_valid && rx_sop;
			fwd_byte_ff  <= rx_valid ? rx_byte : 8'h00;
		end
	end

	assign rx_take = rx_valid && (rx_sop || rx_busy_ff);

	// Bit-time counter; a fresh start of packet always restarts the count.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rx_cnt_ff  <= 3'h0;
			rx_busy_ff <= 1'b0;
		end else if (rx_valid && rx_sop) begin
			rx_cnt_ff  <= 3'h1;
			rx_busy_ff <= 1'b1;
		end else if (rx_take) begin
			rx_cnt_ff  <= rx_cnt_ff + 3'h1;
			rx_busy_ff <= rx_cnt_ff != smpm_pkg::RX_LAST_BT;
		end
	end

	// Field capture in the bit-time layout of the request packet.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rx_code_ff <= 6'h00;
			rx_cmd_ff  <= 12'h000;
			rx_addr_ff <= 16'h0000;
		end else if (rx_take) begin
			case (rx_sop ? 3'h0 : rx_cnt_ff) // [R16]
				3'h0: begin
					rx_code_ff <= rx_byte[5:0];
				end
				3'h4: begin
					rx_cmd_ff[7:0] <= rx_byte;
				end
				3'h5: begin
					rx_cmd_ff[11:8] <= rx_byte[3:0];
				end
				3'h6: begin
					rx_addr_ff[7:0] <= rx_byte;
				end
				3'h7: begin
					rx_addr_ff[15:8] <= rx_byte;
				end
				default: begin
					rx_code_ff <= rx_code_ff;
				end
			endcase
		end
	end

	// Marks the cycle after the last bit-time, when all fields are present.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rx_done_ff <= 1'b0;
		end else begin
			rx_done_ff <= rx_take && !rx_sop && rx_cnt_ff == smpm_pkg::RX_LAST_BT;
		end
	end

	// A broadcast aimed at exactly the system-management address is a request.
	assign sm_hit = rx_done_ff && rx_code_ff == smpm_pkg::CMD_BROADCAST
		&& rx_addr_ff == SYSMGT_BASE; // [R17]

	assign dec_bus.cmd = rx_cmd_ff;

	smpm_cmd_decode u_decode (
		.dec (dec_bus.decoder)
	);

	// ========================================================
	// Command effects
	// Reserved codes raise nothing; management codes raise the manager pulse only when configuration is enabled.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sm_event_ff    <= 1'b0;
			sm_cmd_ff      <= 12'h000;
			shutdown_ff    <= 1'b0;
			halt_ff        <= 1'b0;
			int_pending_ff <= 1'b0;
			vendor_vw_ff   <= 1'b0;
			legacy_cmd_ff  <= 1'b0;
			central_link_manager_cmd_ff    <= 1'b0;
		end else begin
			sm_event_ff    <= sm_hit && dec_bus.cls != smpm_pkg::CLS_RSV; // [R23]
			sm_cmd_ff      <= sm_hit ? rx_cmd_ff : sm_cmd_ff;
			shutdown_ff    <= sm_hit && dec_bus.cls == smpm_pkg::CLS_SHUT; // [R19]
			halt_ff        <= sm_hit && dec_bus.cls == smpm_pkg::CLS_HALT; // [R19]
			int_pending_ff <= sm_hit && dec_bus.cls == smpm_pkg::CLS_INTP; // [R21]
			vendor_vw_ff   <= sm_hit && dec_bus.cls == smpm_pkg::CLS_VEND; // [R21]
			legacy_cmd_ff  <= sm_hit && dec_bus.cls == smpm_pkg::CLS_X86;
			central_link_manager_cmd_ff    <= sm_hit && dec_bus.cls == smpm_pkg::CLS_CENTRAL_LINK_MANAGER
				&& feature_en_ff[0]; // [R10]
		end
	end

	// Virtual interrupt wires follow assert and deassert messages.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			intx_wire_ff <= 4'h0;
		end else if (sm_hit && dec_bus.cls == smpm_pkg::CLS_INTX) begin
			intx_wire_ff[rx_cmd_ff[3:2]] <= rx_cmd_ff[1]; // [R20]
		end
	end

	// ========================================================
	// Upstream request framing
	// A request is taken while ready; ready drops for the twelve bit-times sent.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			up_busy_ff   <= 1'b0;
			up_cnt_ff    <= 4'h0;
			up_cmd_ff    <= 12'h000;
			up_unit_ff   <= 5'h00;
			req_ready_ff <= 1'b0;
		end else if (!up_busy_ff && req_valid && req_ready_ff) begin
			up_busy_ff   <= 1'b1;
			up_cnt_ff    <= 4'h0;
			up_cmd_ff    <= req_cmd;
			up_unit_ff   <= req_unit;
			req_ready_ff <= 1'b0;
		end else if (up_busy_ff) begin
			up_cnt_ff    <= up_cnt_ff + 4'h1;
			up_busy_ff   <= up_cnt_ff != smpm_pkg::UP_LAST_BT;
			req_ready_ff <= 1'b0;
		end else begin
			req_ready_ff <= 1'b1;
		end
	end

	// Bit-time contents; count, masks, chain and data error are all zero.
	always_comb begin
		case (up_cnt_ff) // [R15] [R16]
			4'h0: begin
				nxt_up_byte = {2'b00, smpm_pkg::CMD_SIZED_WRITE};
			end
			4'h1: begin
				nxt_up_byte = {3'b000, up_unit_ff};
			end
			4'h4: begin
				nxt_up_byte = up_cmd_ff[7:0];
			end
			4'h5: begin
				nxt_up_byte = {4'h0, up_cmd_ff[11:8]};
			end
			4'h6: begin
				nxt_up_byte = SYSMGT_BASE[7:0];
			end
			4'h7: begin
				nxt_up_byte = SYSMGT_BASE[15:8];
			end
			default: begin
				nxt_up_byte = 8'h00;
			end
		endcase
	end

	// Registered transmit bit-time stream.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			up_valid_ff <= 1'b0;
			up_sop_ff   <= 1'b0;
			up_byte_ff  <= 8'h00;
		end else begin
			up_valid_ff <= up_busy_ff;
			up_sop_ff   <= up_busy_ff && up_cnt_ff == 4'h0;
			up_byte_ff  <= up_busy_ff ? nxt_up_byte : 8'h00;
		end
	end
endmodule : smpm_top
`default_nettype wire

// File: rtl/smpm_pkg.sv
// Constants and types shared by the power-management capability and request logic.
package smpm_pkg;
	// ========================================================
	// Capability header
	localparam logic [7:0]  CAP_ID          = 8'h08;
	localparam logic [4:0]  CAP_TYPE        = 5'h1C;
	localparam int          HDR_ID_LSB      = 0;
	localparam int          HDR_PTR_LSB     = 8;
	localparam int          HDR_IDX_LSB     = 16;
	localparam int          HDR_TYPE_LSB    = 27;
	localparam logic        SEL_HEADER      = 1'h0;
	localparam logic        SEL_DATA_PORT   = 1'h1;

	// ========================================================
	// Indirect register indices
	localparam logic [7:0]  IDX_FEATURE     = 8'h00;
	localparam logic [7:0]  IDX_FREQ        = 8'h01;
	localparam logic [7:0]  IDX_REFRESH     = 8'h02;

	// ========================================================
	// Feature configuration fields
	localparam int          EN_LSB          = 16;
	localparam int          SUP_FREQ_BIT    = 3;
	localparam logic [5:0]  EN_WARM_MASK    = 6'h23;
	localparam logic [5:0]  FEATURE_RST     = 6'h00;
	localparam logic [15:0] FREQ_RST        = 16'h0000;
	localparam int          INT_LSB         = 6;
	localparam logic [11:0] REFRESH_RST     = 12'h000;

	// ========================================================
	// Packet formats
	localparam logic [5:0]  CMD_SIZED_WRITE = 6'h29;
	localparam logic [5:0]  CMD_BROADCAST   = 6'h3A;
	localparam logic [3:0]  UP_LAST_BT      = 4'hB;
	localparam logic [2:0]  RX_LAST_BT      = 3'h7;

	// ========================================================
	// Command classes and code points
	typedef enum logic [2:0] {
		CLS_RSV  = 3'b000,
		CLS_X86  = 3'b001,
		CLS_SHUT = 3'b010,
		CLS_HALT = 3'b011,
		CLS_INTX = 3'b100,
		CLS_INTP = 3'b101,
		CLS_VEND = 3'b110,
		CLS_CENTRAL_LINK_MANAGER = 3'b111
	} smpm_cls_type;
	localparam logic [7:0]  CMDH_RSV        = 8'h00;
	localparam logic [7:0]  CMDH_SHUT       = 8'h04;
	localparam logic [7:0]  CMDH_HALT       = 8'h05;
	localparam logic [7:0]  CMDH_INTX       = 8'h0B;
	localparam logic [11:0] CMD_INTP        = 12'h0E0;
	localparam logic [11:0] CMD_X86_E1      = 12'h0E1;
	localparam logic [11:0] CMD_VEND_LO     = 12'h0E2;
	localparam logic [11:0] CMD_VEND_HI     = 12'h0FF;
	localparam logic [4:0]  CMDH_CENTRAL_LINK_MANAGER       = 5'h02;
	localparam logic [11:0] CMD_X86_TOP     = 12'h2FF;
endpackage : smpm_pkg

// File: rtl/smpm_dec_if.sv
// Interface carrying a system-management command to its decoder and the class back.
`timescale 1ns/1ps
`default_nettype none
interface smpm_dec_if;
	logic [11:0]                 cmd;
	smpm_pkg::smpm_cls_type      cls;
	modport requester (output cmd, input cls);
	modport decoder   (input cmd, output cls);
endinterface : smpm_dec_if
`default_nettype wire

// File: rtl/smpm_cmd_decode.sv
// Combinational classifier of the twelve-bit system-management command.
`timescale 1ns/1ps
`default_nettype none
module smpm_cmd_decode (
	smpm_dec_if.decoder dec
);
	// ========================================================
	// Classification
	// All twelve bits take part, so newer code points never alias older ones.
	always_comb begin
		if (dec.cmd[11:4] == smpm_pkg::CMDH_RSV) begin // [R18]
			dec.cls = smpm_pkg::CLS_RSV;
		end else if (dec.cmd[11:4] == smpm_pkg::CMDH_SHUT) begin // [R19]
			dec.cls = smpm_pkg::CLS_SHUT;
		end else if (dec.cmd[11:4] == smpm_pkg::CMDH_HALT) begin // [R19]
			dec.cls = smpm_pkg::CLS_HALT;
		end else if (dec.cmd[11:4] == smpm_pkg::CMDH_INTX) begin // [R20]
			dec.cls = smpm_pkg::CLS_INTX;
		end else if (dec.cmd == smpm_pkg::CMD_INTP) begin // [R21]
			dec.cls = smpm_pkg::CLS_INTP;
		end else if (dec.cmd == smpm_pkg::CMD_X86_E1) begin
			dec.cls = smpm_pkg::CLS_X86;
		end else if (dec.cmd >= smpm_pkg::CMD_VEND_LO && dec.cmd <= smpm_pkg::CMD_VEND_HI) begin
			dec.cls = smpm_pkg::CLS_VEND; // [R21]
		end else if (dec.cmd[11:7] == smpm_pkg::CMDH_CENTRAL_LINK_MANAGER) begin
			dec.cls = smpm_pkg::CLS_CENTRAL_LINK_MANAGER;
		end else if (dec.cmd <= smpm_pkg::CMD_X86_TOP) begin
			dec.cls = smpm_pkg::CLS_X86;
		end else begin
			dec.cls = smpm_pkg::CLS_RSV; // [R23]
		end
	end
endmodule : smpm_cmd_decode
`default_nettype wire

// File: test/smpm_top_assertions.sv
// Checker bound to the capability block; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module smpm_top_assertions #(
	parameter logic [7:0]  NEXT_PTR    = 8'h00,
	parameter logic [5:0]  SUPPORT     = 6'h3F,
	parameter logic [15:0] SYSMGT_BASE = 16'h0000
) (
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire logic        warm_rst_b,
	input wire logic        cfg_req,
	input wire logic        cfg_wr,
	input wire logic        cfg_sel,
	input wire logic        cfg_ack_ff,
	input wire logic [31:0] cfg_rdata_ff,
	input wire logic        rx_valid,
	input wire logic        rx_sop,
	input wire logic [7:0]  rx_byte,
	input wire logic        fwd_valid_ff,
	input wire logic        fwd_sop_ff,
	input wire logic [7:0]  fwd_byte_ff,
	input wire logic        req_valid,
	input wire logic        req_ready_ff,
	input wire logic        up_valid_ff,
	input wire logic        up_sop_ff,
	input wire logic [7:0]  up_byte_ff,
	input wire logic        shutdown_ff,
	input wire logic        halt_ff,
	input wire logic        sm_event_ff,
	input wire logic [5:0]  feature_en_ff
);
	logic [3:0] up_cnt_ff;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	// ========================================================
	// Bit-time counter
	// Bit-time index of the upstream packet.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			up_cnt_ff <= 4'h0;
		else
			up_cnt_ff <= up_valid_ff ? up_cnt_ff + 4'h1 : 4'h0;
	end

	// ========================================================
	// Properties
	a_ack_follows_req: assert property (cfg_req |=> cfg_ack_ff)
		else $error("no config answer");
	a_ack_single: assert property (!cfg_req |=> !cfg_ack_ff)
		else $error("stray config answer");
	a_header_fixed: assert property (cfg_req && !cfg_wr && !cfg_sel |=>
		cfg_rdata_ff[7:0] == 8'h08 && cfg_rdata_ff[31:27] == 5'h1C)
		else $error("header id or type");
	a_header_ptr: assert property (cfg_req && !cfg_wr && !cfg_sel |=>
		cfg_rdata_ff[15:8] == NEXT_PTR)
		else $error("header pointer");
	a_fwd_copy: assert property (rx_valid |=> fwd_valid_ff &&
		fwd_sop_ff == $past(rx_sop) && fwd_byte_ff == $past(rx_byte))
		else $error("forward altered");
	a_up_start: assert property (req_valid && req_ready_ff |=>
		!req_ready_ff ##1 up_sop_ff && up_byte_ff == 8'h29)
		else $error("upstream start");
	a_up_length: assert property ($fell(up_valid_ff) |-> up_cnt_ff == 4'hC)
		else $error("upstream length");
	a_up_zero_fields: assert property (up_valid_ff &&
		up_cnt_ff inside {4'h2, 4'h3, [4'h8:4'hB]} |-> up_byte_ff == 8'h00)
		else $error("upstream zero field");
	a_up_address: assert property (up_valid_ff && up_cnt_ff == 4'h6 |->
		up_byte_ff == SYSMGT_BASE[7:0] ##1 up_byte_ff == SYSMGT_BASE[15:8])
		else $error("upstream address");
	a_special_event: assert property (shutdown_ff || halt_ff |->
		sm_event_ff && !(shutdown_ff && halt_ff))
		else $error("special cycle pulse");
	a_warm_clears: assert property (!warm_rst_b |=>
		feature_en_ff[5] == 1'h0 && feature_en_ff[1:0] == 2'h0)
		else $error("warm enable left set");
	a_warm_keeps: assert property (!warm_rst_b && !cfg_req |=>
		$stable(feature_en_ff[4:2]))
		else $error("cold enable disturbed");

	// Main scenarios reached.
	c_up_last: cover property (up_valid_ff && up_cnt_ff == 4'hB);
	c_shutdown: cover property (shutdown_ff);
	c_warm: cover property (!warm_rst_b ##1 warm_rst_b);
endmodule : smpm_top_assertions

bind smpm_top smpm_top_assertions #(
	.NEXT_PTR(NEXT_PTR),
	.SUPPORT(SUPPORT),
	.SYSMGT_BASE(SYSMGT_BASE)
) u_chk (.*);
`default_nettype wire

// File: test/smpm_host_model.sv
// Host model that issues downstream broadcasts and collects upstream requests.
`timescale 1ns/1ps
`default_nettype none
module smpm_host_model (
	input  wire logic       clk_sys,
	output var  logic       rx_valid,
	output var  logic       rx_sop,
	output var  logic [7:0] rx_byte,
	input  wire logic       up_valid_ff,
	input  wire logic       up_sop_ff,
	input  wire logic [7:0] up_byte_ff
);
	logic [7:0] cap [24];
	int         ncap = 0;
	int         nsop = 0;

	// Link starts idle.
	initial
		{rx_valid, rx_sop, rx_byte} = 10'h000;

	// Captures upstream bit-times and counts packet starts.
	always @(posedge clk_sys) begin
		if (up_valid_ff && ncap < 24) begin
			cap[ncap] <= up_byte_ff;
			ncap <= ncap + 1;
		end
		nsop <= nsop + int'(up_sop_ff);
	end

	// Sends one broadcast; a gap after bit-time 3 models a slow sender.
	task automatic send(input logic [5:0] code, input logic [11:0] cmd,
		input logic [15:0] addr, input bit gap);
		logic [7:0] bt [8];
		bt = '{{2'h0, code}, 8'h00, 8'h00, 8'h00, cmd[7:0],
			{4'h0, cmd[11:8]}, addr[7:0], addr[15:8]};
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			rx_valid <= 1'h1;
			rx_sop <= (i == 0);
			rx_byte <= bt[i];
			if (gap && i == 3) begin
				@(posedge clk_sys);
				rx_valid <= 1'h0;
				rx_byte <= ~bt[i];
			end
		end
		@(posedge clk_sys);
		rx_valid <= 1'h0;
		rx_sop <= 1'h0;
		rx_byte <= ~bt[7];
	endtask : send
endmodule : smpm_host_model
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the capability block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [15:0] BASE = 16'hA5C3;
	logic clk_sys, rst_b, warm_rst_b, cfg_req, cfg_wr, cfg_sel, cfg_ack_ff;
	logic [3:0] cfg_be, intx_wire_ff;
	logic [31:0] cfg_wdata, cfg_rdata_ff;
	wire logic rx_valid, rx_sop;
	wire logic [7:0] rx_byte;
	logic fwd_valid_ff, fwd_sop_ff, req_valid, req_ready_ff, up_valid_ff, up_sop_ff;
	logic [7:0] fwd_byte_ff, up_byte_ff;
	logic [11:0] req_cmd, sm_cmd_ff, refresh_cfg_ff;
	logic [4:0] req_unit;
	logic sm_event_ff, shutdown_ff, halt_ff, int_pending_ff;
	logic vendor_vw_ff, legacy_cmd_ff, central_link_manager_cmd_ff;
	logic [5:0] feature_en_ff;
	logic [15:0] allowed_freq_mask_ff;
	logic [6:0] seen;
	int failures = 0, checked = 0, cyc = 0;

	smpm_top #(.SYSMGT_BASE(BASE)) dut (.*);
	smpm_host_model host (.*);

	// Clock at 200 MHz.
	always #2.5 clk_sys = ~clk_sys;

	// Gathers class pulses and cuts a hang short.
	always @(posedge clk_sys) begin
		seen <= (rx_valid && rx_sop ? 7'h00 : seen) | {sm_event_ff, shutdown_ff, halt_ff, int_pending_ff,
			vendor_vw_ff, legacy_cmd_ff, central_link_manager_cmd_ff};
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			failures++;
			tally_and_finish();
		end
	end

	// ========================================================
	// Common tasks
	task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish

	// One config access; the answer is judged just after the edge that takes it.
	task automatic cfg(input bit wr, input bit sel, input logic [3:0] be,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk_sys);
		{cfg_req, cfg_wr, cfg_sel, cfg_be, cfg_wdata} <= {1'h1, wr, sel, be, wd};
		@(posedge clk_sys);
		cfg_req <= 1'h0;
		#1;
		check("cfg_ack", cfg_ack_ff, 32'h1);
		rd = cfg_rdata_ff;
	endtask : cfg

	// Selects an index, writes the data port, reads it back.
	task automatic reg_rw(input logic [7:0] idx, input logic [3:0] be,
		input logic [31:0] wd, input logic [31:0] exp);
		logic [31:0] rd;
		cfg(1'h1, 1'h0, 4'h4, {8'h00, idx, 16'h0000}, rd);
		cfg(1'h1, 1'h1, be, wd, rd);
		cfg(1'h0, 1'h1, 4'h0, 32'h0, rd);
		check("data_port", rd, exp);
	endtask : reg_rw

	// Sends a broadcast and judges the class pulses that follow it.
	task automatic rx_case(input logic [5:0] code, input logic [11:0] cmd,
		input logic [15:0] addr, input logic [6:0] exp, input logic [6:0] mask);
		host.send(code, cmd, addr, cmd[0]);
		repeat (6) @(posedge clk_sys);
		#1;
		check("class", seen & mask, exp);
		if (exp[6])
			check("sm_cmd", sm_cmd_ff, cmd);
	endtask : rx_case

	// ========================================================
	// Scenarios
	task automatic s_regs;
		logic [31:0] rd;
		reg_rw(8'h00, 4'hF, 32'hFFFFFFFF, 32'h003F003F);
		check("feature_en", feature_en_ff, 32'h3F);
		reg_rw(8'h01, 4'hF, 32'hFFFFFFFF, 32'h0000FFFF);
		reg_rw(8'h01, 4'h1, 32'h0, 32'h0000FF00);
		check("freq_mask", allowed_freq_mask_ff, 32'hFF00);
		reg_rw(8'h02, 4'hF, 32'hFFFFFFFF, 32'h00000FFF);
		check("refresh", refresh_cfg_ff, 32'hFFF);
		reg_rw(8'h03, 4'hF, 32'hFFFFFFFF, 32'h0);
		cfg(1'h0, 1'h0, 4'h0, 32'h0, rd);
		check("header", rd & 32'hF8FFFFFF, 32'hE0030008);
	endtask : s_regs

	task automatic s_rx;
		logic [11:0] c [14] = '{12'h043, 12'h05F, 12'h0B2, 12'h0B6, 12'h0BA, 12'h0BE,
			12'h0B0, 12'h0E0, 12'h0E2, 12'h0FF, 12'h0E1, 12'h143, 12'h003, 12'h300};
		logic [6:0] e [14] = '{7'h60, 7'h50, 7'h40, 7'h40, 7'h40, 7'h40, 7'h40,
			7'h48, 7'h44, 7'h44, 7'h42, 7'h41, 7'h00, 7'h00};
		logic [3:0] w [14] = '{4'h0, 4'h0, 4'h1, 4'h3, 4'h7, 4'hF, 4'hE,
			4'hE, 4'hE, 4'hE, 4'hE, 4'hE, 4'hE, 4'hE};
		for (int i = 0; i < 14; i++) begin
			rx_case(6'h3A, c[i], BASE, e[i], 7'h7F);
			check("intx", intx_wire_ff, w[i]);
		end
		rx_case(6'h2C, 12'h043, BASE, 7'h00, 7'h7F);
		rx_case(6'h3A, 12'h043, ~BASE, 7'h00, 7'h7F);
	endtask : s_rx

	// Two back-to-back requests; the second waits for ready.
	task automatic s_up;
		logic [11:0] cmd [2] = '{12'h0B6, 12'h0E1};
		logic [4:0] unit [2] = '{5'h05, 5'h1F};
		logic [7:0] e [12];
		bit r;
		@(posedge clk_sys);
		for (int p = 0; p < 2; p++) begin
			{req_valid, req_cmd, req_unit} <= {1'h1, cmd[p], unit[p]};
			r = 1'h0;
			for (int n = 0; n < 40 && !r; n++) begin
				#1;
				r = req_ready_ff;
				@(posedge clk_sys);
			end
			check("up_take", r, 32'h1);
		end
		req_valid <= 1'h0;
		repeat (16) @(posedge clk_sys);
		#1;
		check("up_count", host.nsop, 32'h2);
		for (int p = 0; p < 2; p++) begin
			e = '{8'h29, {3'h0, unit[p]}, 8'h00, 8'h00, cmd[p][7:0], {4'h0, cmd[p][11:8]},
				BASE[7:0], BASE[15:8], 8'h00, 8'h00, 8'h00, 8'h00};
			for (int k = 0; k < 12; k++)
				check("up_byte", host.cap[p * 12 + k], e[k]);
		end
	endtask : s_up

	// Warm then cold reset: warm clears only its own fields, cold clears all enables.
	task automatic s_resets;
		@(posedge clk_sys);
		warm_rst_b <= 1'h0;
		@(posedge clk_sys);
		warm_rst_b <= 1'h1;
		#1;
		check("en_warm", feature_en_ff, 32'h1C);
		check("freq_warm", allowed_freq_mask_ff, 32'h0);
		check("refr_warm", refresh_cfg_ff, 32'h0);
		rx_case(6'h3A, 12'h143, BASE, 7'h00, 7'h01);
		@(posedge clk_sys);
		rst_b <= 1'h0;
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'h1;
		#1;
		check("en_cold", feature_en_ff, 32'h0);
		reg_rw(8'h00, 4'hF, 32'h0, 32'h0000003F);
	endtask : s_resets

	// Main sequence.
	initial begin
		{clk_sys, rst_b, cfg_req, cfg_wr, cfg_sel, cfg_be, cfg_wdata, req_valid, req_cmd, req_unit} = '0;
		warm_rst_b = 1'h1;
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'h1;
		s_regs();
		s_rx();
		s_up();
		s_resets();
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
